// ### rtl/iplr_top.v
// Priority level registers for 21 interrupt sources with APB access and request gating
//
// Operation
// - Field 00 disables, 01 is level 0, 10 level 1, 11 level 2.
// - Every priority field resets to the disabled encoding.
// - Covered sources never reach a level above 2.
// - Reserved pairs read zero and ignore writes.
// - Sixth register bits 7-6 hold timer D channel 0 level.
// - Sixth register bits 3-2 hold decoder 0 index level.
// - Sixth register bits 1-0 hold decoder 0 home or watchdog level.
// - Seventh register bits 15-14 hold timer A channel 0 level.
// - Seventh register bits 13-6 hold timer B channels 3 down to 0.
// - Seventh register bits 5-0 hold timer C channels 3, 2, 1.
// - Eighth register bits 15-12 hold serial 0 receive full and error.
// - Eighth register bits 9-6 hold serial 0 transmit idle and empty.
// - Eighth register bits 5-0 hold timer A channels 3, 2, 1.
// - Ninth register bits 15-12 hold PWM A and B fault levels.
// - Ninth register bits 11-10 hold PWM A reload level.
// - Sixth register sits at word index 6, 16 bits wide.
//
// Source index map for I_SRC_REQ, O_REQ_VALID and O_REQ_LEVEL (two bits each):
//  0 decoder0_home_wdog, 1 decoder0_index, 2 timer_d_ch0, 3..5 timer_c_ch1..3,
//  6..9 timer_b_ch0..3, 10..13 timer_a_ch0..3, 14 serial0_tx_empty,
//  15 serial0_tx_idle, 16 serial0_rx_error, 17 serial0_rx_full,
//  18 pwm_a_reload, 19 pwm_b_fault, 20 pwm_a_fault

`include "iplr_defines.vh"

module iplr_top (
  input wire I_CLK,
  input wire I_SYS_RST,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output reg O_PREADY,
  output reg O_PSLVERR,
  input wire [20:0] I_SRC_REQ,
  output reg [20:0] O_REQ_VALID,
  output reg [41:0] O_REQ_LEVEL
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Field to level: 01 -> 0, 10 -> 1, 11 -> 2; 00 yields 0 but is never forwarded
  function [1:0] iplr_level;
    input [1:0] field;
    begin
      if (field == `IPLR_FIELD_DISABLED) begin
        iplr_level = 2'h0;
      end else begin
        iplr_level = field - 2'h1;
      end
    end
  endfunction

  function iplr_enabled;
    input [1:0] field;
    begin
      iplr_enabled = (field != `IPLR_FIELD_DISABLED);
    end
  endfunction

  // Read word; the upper half does not exist in these 16-bit registers
  function [31:0] iplr_read_word;
    input [15:0] value;
    input [15:0] mask;
    begin
      iplr_read_word = {16'h0000, value & mask};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  reg [15:0] timer_d_decoder_priority_r;
  reg [15:0] timer_a_b_c_priority_r;
  reg [15:0] serial0_timer_a_priority_r;
  reg [15:0] pwm_adc_priority_r;

  wire [9:0] word_idx;
  wire hit_d_dec;
  wire hit_abc;
  wire hit_ser;
  wire hit_pwm;
  wire mapped;
  wire setup;
  wire wr_go;
  wire wr_d_dec;
  wire wr_abc;
  wire wr_ser;
  wire wr_pwm;
  reg [31:0] rdata_nxt;

  assign word_idx = I_PADDR[11:2];
  assign hit_d_dec = (word_idx == `IPLR_IDX_TIMER_D_DECODER);
  assign hit_abc = (word_idx == `IPLR_IDX_TIMER_A_B_C);
  assign hit_ser = (word_idx == `IPLR_IDX_SERIAL0_TIMER_A);
  assign hit_pwm = (word_idx == `IPLR_IDX_PWM_ADC);
  assign mapped = hit_d_dec | hit_abc | hit_ser | hit_pwm;
  assign setup = I_PSEL & ~I_PENABLE;
  // Writes land only at the completing edge of the access phase
  assign wr_go = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & mapped;
  assign wr_d_dec = wr_go & hit_d_dec;
  assign wr_abc = wr_go & hit_abc;
  assign wr_ser = wr_go & hit_ser;
  assign wr_pwm = wr_go & hit_pwm;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Masking at write time keeps reserved and uncovered bits at zero
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      timer_d_decoder_priority_r <= `IPLR_RST_TIMER_D_DECODER;
    end else if (wr_d_dec) begin
      timer_d_decoder_priority_r <= I_PWDATA[15:0] & `IPLR_MASK_TIMER_D_DECODER;
    end
  end

  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      timer_a_b_c_priority_r <= `IPLR_RST_TIMER_A_B_C;
    end else if (wr_abc) begin
      timer_a_b_c_priority_r <= I_PWDATA[15:0] & `IPLR_MASK_TIMER_A_B_C;
    end
  end

  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      serial0_timer_a_priority_r <= `IPLR_RST_SERIAL0_TIMER_A;
    end else if (wr_ser) begin
      serial0_timer_a_priority_r <= I_PWDATA[15:0] & `IPLR_MASK_SERIAL0_TIMER_A;
    end
  end

  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pwm_adc_priority_r <= `IPLR_RST_PWM_ADC;
    end else if (wr_pwm) begin
      pwm_adc_priority_r <= I_PWDATA[15:0] & `IPLR_MASK_PWM_ADC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read and response

  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (hit_d_dec) begin
      rdata_nxt = iplr_read_word(timer_d_decoder_priority_r, `IPLR_MASK_TIMER_D_DECODER);
    end else if (hit_abc) begin
      rdata_nxt = iplr_read_word(timer_a_b_c_priority_r, `IPLR_MASK_TIMER_A_B_C);
    end else if (hit_ser) begin
      rdata_nxt = iplr_read_word(serial0_timer_a_priority_r, `IPLR_MASK_SERIAL0_TIMER_A);
    end else if (hit_pwm) begin
      rdata_nxt = iplr_read_word(pwm_adc_priority_r, `IPLR_MASK_PWM_ADC);
    end
  end

  // Response is prepared in the setup cycle so the access phase has no wait state
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= setup;
      O_PSLVERR <= setup & ~mapped;
    end
  end

  // Write setups clear the data too, so an error answer never carries stale read data
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (setup & ~I_PWRITE) begin
      O_PRDATA <= rdata_nxt;
    end else if (setup | ~I_PSEL) begin
      O_PRDATA <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction in source-index order

  wire [1:0] decoder0_home_wdog_level;
  wire [1:0] decoder0_index_level;
  wire [1:0] timer_d_ch0_level;
  wire [1:0] timer_c_ch1_level;
  wire [1:0] timer_c_ch2_level;
  wire [1:0] timer_c_ch3_level;
  wire [1:0] timer_b_ch0_level;
  wire [1:0] timer_b_ch1_level;
  wire [1:0] timer_b_ch2_level;
  wire [1:0] timer_b_ch3_level;
  wire [1:0] timer_a_ch0_level;
  wire [1:0] timer_a_ch1_level;
  wire [1:0] timer_a_ch2_level;
  wire [1:0] timer_a_ch3_level;
  wire [1:0] serial0_tx_empty_level;
  wire [1:0] serial0_tx_idle_level;
  wire [1:0] serial0_rx_error_level;
  wire [1:0] serial0_rx_full_level;
  wire [1:0] pwm_a_reload_level;
  wire [1:0] pwm_b_fault_level;
  wire [1:0] pwm_a_fault_level;
  wire [41:0] fields;

  assign decoder0_home_wdog_level =
    timer_d_decoder_priority_r[`IPLR_LSB_DECODER0_HOME_WDOG +: 2];
  assign decoder0_index_level =
    timer_d_decoder_priority_r[`IPLR_LSB_DECODER0_INDEX +: 2];
  assign timer_d_ch0_level =
    timer_d_decoder_priority_r[`IPLR_LSB_TIMER_D_CH0 +: 2];
  assign timer_c_ch1_level =
    timer_a_b_c_priority_r[`IPLR_LSB_TIMER_C_CH1 +: 2];
  assign timer_c_ch2_level =
    timer_a_b_c_priority_r[`IPLR_LSB_TIMER_C_CH2 +: 2];
  assign timer_c_ch3_level =
    timer_a_b_c_priority_r[`IPLR_LSB_TIMER_C_CH3 +: 2];
  assign timer_b_ch0_level =
    timer_a_b_c_priority_r[`IPLR_LSB_TIMER_B_CH0 +: 2];
  assign timer_b_ch1_level =
    timer_a_b_c_priority_r[`IPLR_LSB_TIMER_B_CH1 +: 2];
  assign timer_b_ch2_level =
    timer_a_b_c_priority_r[`IPLR_LSB_TIMER_B_CH2 +: 2];
  assign timer_b_ch3_level =
    timer_a_b_c_priority_r[`IPLR_LSB_TIMER_B_CH3 +: 2];
  assign timer_a_ch0_level =
    timer_a_b_c_priority_r[`IPLR_LSB_TIMER_A_CH0 +: 2];
  assign timer_a_ch1_level =
    serial0_timer_a_priority_r[`IPLR_LSB_TIMER_A_CH1 +: 2];
  assign timer_a_ch2_level =
    serial0_timer_a_priority_r[`IPLR_LSB_TIMER_A_CH2 +: 2];
  assign timer_a_ch3_level =
    serial0_timer_a_priority_r[`IPLR_LSB_TIMER_A_CH3 +: 2];
  assign serial0_tx_empty_level =
    serial0_timer_a_priority_r[`IPLR_LSB_SERIAL0_TX_EMPTY +: 2];
  assign serial0_tx_idle_level =
    serial0_timer_a_priority_r[`IPLR_LSB_SERIAL0_TX_IDLE +: 2];
  assign serial0_rx_error_level =
    serial0_timer_a_priority_r[`IPLR_LSB_SERIAL0_RX_ERROR +: 2];
  assign serial0_rx_full_level =
    serial0_timer_a_priority_r[`IPLR_LSB_SERIAL0_RX_FULL +: 2];
  assign pwm_a_reload_level =
    pwm_adc_priority_r[`IPLR_LSB_PWM_A_RELOAD +: 2];
  assign pwm_b_fault_level =
    pwm_adc_priority_r[`IPLR_LSB_PWM_B_FAULT +: 2];
  assign pwm_a_fault_level =
    pwm_adc_priority_r[`IPLR_LSB_PWM_A_FAULT +: 2];

  assign fields = {
    pwm_a_fault_level,
    pwm_b_fault_level,
    pwm_a_reload_level,
    serial0_rx_full_level,
    serial0_rx_error_level,
    serial0_tx_idle_level,
    serial0_tx_empty_level,
    timer_a_ch3_level,
    timer_a_ch2_level,
    timer_a_ch1_level,
    timer_a_ch0_level,
    timer_b_ch3_level,
    timer_b_ch2_level,
    timer_b_ch1_level,
    timer_b_ch0_level,
    timer_c_ch3_level,
    timer_c_ch2_level,
    timer_c_ch1_level,
    timer_d_ch0_level,
    decoder0_index_level,
    decoder0_home_wdog_level
  };

  ////////////////////////////////////////////////////////////////////////////
  // Request gating toward the priority encoder

  reg [20:0] valid_nxt;
  reg [41:0] level_nxt;
  integer i;

  always @* begin
    valid_nxt = 21'h000000;
    level_nxt = 42'h000_0000_0000;
    for (i = 0; i < `IPLR_NUM_SRC; i = i + 1) begin
      if (I_SRC_REQ[i] && iplr_enabled(fields[2*i +: 2])) begin
        valid_nxt[i] = 1'b1;
        level_nxt[2*i +: 2] = iplr_level(fields[2*i +: 2]);
      end
    end
  end

  // One register stage; a disabled source shows level 0 with valid low
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_REQ_VALID <= 21'h000000;
      O_REQ_LEVEL <= 42'h000_0000_0000;
    end else begin
      O_REQ_VALID <= valid_nxt;
      O_REQ_LEVEL <= level_nxt;
    end
  end

endmodule // iplr_top

// ### rtl/iplr_defines.vh
// Constants for the interrupt priority level register slice
`ifndef IPLR_DEFINES_VH
`define IPLR_DEFINES_VH

// Register indices; byte address on the bus is four times the index
`define IPLR_IDX_TIMER_D_DECODER 10'h006
`define IPLR_IDX_TIMER_A_B_C 10'h007
`define IPLR_IDX_SERIAL0_TIMER_A 10'h008
`define IPLR_IDX_PWM_ADC 10'h009

// Writable bits of each register; the rest are reserved or outside this slice
`define IPLR_MASK_TIMER_D_DECODER 16'h00cf
`define IPLR_MASK_TIMER_A_B_C 16'hffff
`define IPLR_MASK_SERIAL0_TIMER_A 16'hf3ff
`define IPLR_MASK_PWM_ADC 16'hfc00

// Reset values
`define IPLR_RST_TIMER_D_DECODER 16'h0000
`define IPLR_RST_TIMER_A_B_C 16'h0000
`define IPLR_RST_SERIAL0_TIMER_A 16'h0000
`define IPLR_RST_PWM_ADC 16'h0000

// Field encodings
`define IPLR_FIELD_DISABLED 2'h0
`define IPLR_LEVEL_MAX 2'h2

// Field low-bit positions within their registers
`define IPLR_LSB_TIMER_D_CH0 6
`define IPLR_LSB_DECODER0_INDEX 2
`define IPLR_LSB_DECODER0_HOME_WDOG 0
`define IPLR_LSB_TIMER_A_CH0 14
`define IPLR_LSB_TIMER_B_CH3 12
`define IPLR_LSB_TIMER_B_CH2 10
`define IPLR_LSB_TIMER_B_CH1 8
`define IPLR_LSB_TIMER_B_CH0 6
`define IPLR_LSB_TIMER_C_CH3 4
`define IPLR_LSB_TIMER_C_CH2 2
`define IPLR_LSB_TIMER_C_CH1 0
`define IPLR_LSB_SERIAL0_RX_FULL 14
`define IPLR_LSB_SERIAL0_RX_ERROR 12
`define IPLR_LSB_SERIAL0_TX_IDLE 8
`define IPLR_LSB_SERIAL0_TX_EMPTY 6
`define IPLR_LSB_TIMER_A_CH3 4
`define IPLR_LSB_TIMER_A_CH2 2
`define IPLR_LSB_TIMER_A_CH1 0
`define IPLR_LSB_PWM_A_FAULT 14
`define IPLR_LSB_PWM_B_FAULT 12
`define IPLR_LSB_PWM_A_RELOAD 10

// Number of covered sources
`define IPLR_NUM_SRC 21

`endif

// ### sim/iplr_chk_sva.sv
// Concurrent checks on the ports of the priority level register slice
module iplr_chk (
  input wire I_CLK,
  input wire I_SYS_RST,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire [11:0] I_PADDR,
  input wire [20:0] I_SRC_REQ,
  input wire [31:0] O_PRDATA,
  input wire O_PREADY,
  input wire O_PSLVERR,
  input wire [20:0] O_REQ_VALID,
  input wire [41:0] O_REQ_LEVEL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  reset_clear_a: assert property ($fell(I_SYS_RST) |-> O_REQ_VALID == 21'h0 && O_REQ_LEVEL == 42'h0)
    else $error("request outputs not clear after reset");
  req_gate_a: assert property ((O_REQ_VALID & ~$past(I_SRC_REQ)) == 21'h0)
    else $error("valid without a request");
  level_max_a: assert property ((O_REQ_LEVEL & (O_REQ_LEVEL >> 1) & 42'h15555555555) == 42'h0)
    else $error("level above two forwarded");
  idle_level_a: assert property (!O_REQ_VALID[2] |-> O_REQ_LEVEL[5:4] == 2'h0)
    else $error("level shown for a suppressed source");
  sixth_rsvd_a: assert property (O_PREADY && I_PADDR[11:2] == 10'h006 |-> O_PRDATA[5:4] == 2'h0)
    else $error("reserved pair of sixth register not zero");
  eighth_rsvd_a: assert property (O_PREADY && I_PADDR[11:2] == 10'h008 |-> O_PRDATA[11:10] == 2'h0)
    else $error("reserved pair of eighth register not zero");
  ready_setup_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
    else $error("ready not one cycle after setup");
  slverr_data_a: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
    else $error("error response without ready or with data");
endmodule // iplr_chk

// ### sim/iplr_core_model.sv
// Core-side model: takes the forwarded requests and picks the top level
module iplr_core_model (
  input wire logic [20:0] i_req_valid,
  input wire logic [41:0] i_req_level,
  output logic o_any,
  output logic [1:0] o_top
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    o_any = |i_req_valid;
    o_top = 2'h0;
    for (int k = 0; k < 21; k++) begin
      if (i_req_valid[k] && i_req_level[2*k +: 2] > o_top) begin
        o_top = i_req_level[2*k +: 2];
      end
    end
  end
endmodule // iplr_core_model

// ### sim/iplr_top_tb_top.sv
// Self-checking bench for the priority level register slice
module iplr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwd = 32'h0, rdat;
  logic [20:0] src = 21'h0;
  wire [31:0] prd;
  wire prdy, perr, any;
  wire [20:0] vld;
  wire [41:0] lvl;
  wire [1:0] top;
  int errors = 0, tests_run = 0, cyc = 0;
  iplr_top iplr_top_i (.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy),
    .O_PSLVERR(perr), .I_SRC_REQ(src), .O_REQ_VALID(vld), .O_REQ_LEVEL(lvl));
  iplr_core_model iplr_core_model_i (.i_req_valid(vld), .i_req_level(lvl), .o_any(any),
    .o_top(top));
  initial forever #4 clk = ~clk;
  task summarize;
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bound well above the under two hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  task chk32(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t register got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_req(input [62:0] got, input [62:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t requests got %h exp %h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; returns one idle edge after the one that samples ready
  task automatic apb(input [11:0] a, input w, input [31:0] d, input e);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rdat = prd;
    chk32(perr, e);
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task rd(input [11:0] a, input [31:0] exp, input e);
    apb(a, 0, 32'h0, e);
    chk32(rdat, exp);
  endtask
  function automatic [5:0] loc(input int i);
    if (i < 2) return {2'h0, 4'(2 * i)};
    if (i == 2) return {2'h0, 4'h6};
    if (i < 11) return {2'h1, 4'(2 * (i - 3))};
    if (i < 16) return {2'h2, 4'(2 * (i - 11))};
    if (i < 18) return {2'h2, 4'(2 * (i - 10))};
    return {2'h3, 4'(2 * (i - 13))};
  endfunction
  task reset_values;
    for (int r = 0; r < 4; r++) rd(12'h018 + 12'(4 * r), 32'h0, 0);
  endtask
  task reserved_bits;
    logic [15:0] m[4];
    m = '{16'h00cf, 16'hffff, 16'hf3ff, 16'hfc00};
    for (int r = 0; r < 4; r++) begin
      apb(12'h018 + 12'(4 * r), 1, 32'hffffffff, 0);
      rd(12'h018 + 12'(4 * r), {16'h0, m[r]}, 0);
    end
    apb(12'h028, 1, 32'hffffffff, 1);
    rd(12'h028, 32'h0, 1);
    rd(12'h014, 32'h0, 1);
  endtask
  // Pass p puts code (i + p) mod 4 in field i; requests flip every two passes,
  // so every code meets a raised and a quiet request
  task automatic field_map(input logic [1:0] p);
    logic [15:0] w[4];
    logic [20:0] ev, rq;
    logic [41:0] el;
    logic [1:0] c, tp;
    logic [5:0] l;
    w = '{default: 16'h0};
    ev = 21'h0;
    el = 42'h0;
    tp = 2'h0;
    rq = 21'h0aaaaa ^ {21{p[1]}};
    for (int i = 0; i < 21; i++) begin
      c = 2'(i) + p;
      l = loc(i);
      w[l[5:4]][l[3:0] +: 2] = c;
      if (c != 2'h0 && rq[i]) begin
        ev[i] = 1'b1;
        el[2*i +: 2] = c - 2'h1;
        if (c - 2'h1 > tp) tp = c - 2'h1;
      end
    end
    for (int r = 0; r < 4; r++) begin
      apb(12'h018 + 12'(4 * r), 1, {16'h0, w[r]}, 0);
      rd(12'h018 + 12'(4 * r), {16'h0, w[r]}, 0);
    end
    src <= rq;
    repeat (2) @(posedge clk);
    #1;
    chk_req({vld, lvl}, {ev, el});
    chk_req({any, top}, {|ev, tp});
    @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    reset_values();
    reserved_bits();
    for (int p = 0; p < 4; p++) field_map(2'(p));
    summarize();
  end
endmodule // iplr_top_tb_top
bind iplr_top iplr_chk iplr_chk_i (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR), .I_SRC_REQ(I_SRC_REQ), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_REQ_VALID(O_REQ_VALID),
  .O_REQ_LEVEL(O_REQ_LEVEL));
